// >>> bench/host_model.sv
// Host model: byte reads and writes on the register port.
// Assumes one clock; signals change just after a rising edge.
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic        i_core_clk,
   // Register port
   output logic             o_wr_en,
   output logic             o_rd_en,
   output logic [15:0]      o_addr,
   output logic [7:0]       o_wdata
);
   // Idle bus at time zero
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 16'hbfff;
      o_wdata = 8'h00;
   end
   // One-cycle strobe, then an idle edge so strobes never toggle twice at once
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] v);
      o_addr  <= a;
      o_wdata <= v;
      o_wr_en <= wr;
      o_rd_en <= !wr;
      @(posedge i_core_clk);
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b0;
      o_addr  <= ~a;  // Released bus shows the inverse
      o_wdata <= ~v;
      @(posedge i_core_clk);
   endtask
endmodule

// >>> bench/socket_mode_config_tb.sv
// Bench for the socket mode bank: random and corner writes, reads, opens.
// Assumes host_model drives the register port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module socket_mode_config_tb;
   import socket_mode_pkg::*;
   logic        i_core_clk = 1'b0;
   logic        i_rstn     = 1'b0;
   logic        i_wr_en, i_rd_en, o_hit;
   logic [15:0] i_addr;
   logic [7:0]  i_wdata, o_rdata, d;
   logic [7:0]  i_open     = 8'h00;
   logic        ce         = 1'b1;
   logic [7:0]  mr [8];
   proto_t      o_proto [8];
   logic [7:0]  o_mc, o_mf, o_ack, o_v1;
   logic [7:0]  o_socket_state [8];
   logic [7:0]  est [8];
   logic [3:0]  p;
   int          n_mismatch = 0, num_checks = 0, cyc = 0, k;
   socket_mode_config uut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(ce),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .o_hit(o_hit), .i_open(i_open), .o_proto(o_proto),
      .o_multicast_en(o_mc), .o_mac_filter_enable(o_mf), .o_immediate_ack_enable(o_ack),
      .o_igmp_v1(o_v1), .o_socket_state(o_socket_state));
   host_model host (.i_core_clk(i_core_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
      .o_addr(i_addr), .o_wdata(i_wdata));
   always #50 i_core_clk = ~i_core_clk;
   // Hang guard: the run needs under a thousand cycles
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // Effective protocol: wide codes on socket 0 only, illegal codes close
   function automatic logic [3:0] eproto(input int n, input logic [7:0] v);
      if (v[3:0] > 4'h5 || (n != 0 && v[3:0] > 4'h3))
         return 4'h0;
      return v[3:0];
   endfunction
   // Status after open; closed keeps the old state
   function automatic logic [7:0] estate(input logic [3:0] q, input logic [7:0] old);
      case (q)
         4'h1: return 8'h13;
         4'h2: return 8'h22;
         4'h3: return 8'h32;
         4'h4: return 8'h42;
         4'h5: return 8'h5f;
         default: return old;
      endcase
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Address decode expected for a byte address
   function automatic logic ehit(input logic [15:0] a);
      return a[15:11] == 5'h08 && a[7:0] == 8'h00;
   endfunction
   // Decode checked mid-cycle while a strobe stands
   always @(negedge i_core_clk) begin
      if (i_rstn && (i_wr_en || i_rd_en))
         `CHK("hit", ehit(i_addr), o_hit)
   end
   // Read socket n; n of 12 lands on an unmapped address
   task automatic rd(input int n, input logic [7:0] e);
      host.access(1'b0, 16'h4000 + 16'(n) * 16'h0100, 8'h00);
      `CHK("rdata", e, o_rdata)
   endtask
   // Main sequence: reset values, protocol sweep, random fill
   initial begin
      void'($urandom(90));
      est = '{default: 8'h00};
      repeat (2) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      for (int n = 0; n < 8; n++) begin
         rd(n, 8'h00);
         `CHK("state", 8'h00, o_socket_state[n])
      end
      for (int i = 0; i < 64; i++) begin
         k = i % 8;
         d = 8'($urandom);
         if (i < 48)
            d[3:0] = 4'(i / 8);
         host.access(1'b1, 16'h4000 + 16'(k) * 16'h0100, d);
         mr[k] = d & 8'hef;
         rd(k, mr[k]);
         p = eproto(k, d);
         `CHK("proto", p, o_proto[k])
         `CHK("mcast", d[7] && p == 4'h2, o_mc[k])
         `CHK("filter", d[6] && p == 4'h4, o_mf[k])
         `CHK("ack", d[5] && p == 4'h1, o_ack[k])
         `CHK("igmp", d[5] && d[7] && p == 4'h2, o_v1[k])
         i_open <= 8'h01 << k;
         @(posedge i_core_clk);
         i_open <= 8'h00;
         @(posedge i_core_clk);
         est[k] = estate(p, est[k]);
         `CHK("state", est[k], o_socket_state[k])
      end
      // Multicast open: mode, group address outside this bank, then open
      host.access(1'b1, 16'h4000, 8'ha2);
      host.access(1'b1, 16'h400c, 8'he0);
      rd(0, 8'ha2);
      `CHK("igmp0", 1'b1, o_v1[0])
      i_open <= 8'h01;
      @(posedge i_core_clk);
      i_open <= 8'h00;
      @(posedge i_core_clk);
      `CHK("mopen", 8'h22, o_socket_state[0])
      rd(12, 8'h00);
      host.access(1'b1, 16'h4000, 8'h44);
      `CHK("filter0", 1'b1, o_mf[0])
      // Enable low: write, read and open are all held off
      ce <= 1'b0;
      host.access(1'b1, 16'h4100, ~mr[1]);
      host.access(1'b0, 16'h4000, 8'h00);
      `CHK("frozen_rd", 8'h00, o_rdata)
      i_open <= 8'h02;
      @(posedge i_core_clk);
      i_open <= 8'h00;
      ce     <= 1'b1;
      `CHK("frozen_st", est[1], o_socket_state[1])
      rd(1, mr[1]);
      give_verdict();
   end
endmodule

// >>> hw/socket_mode_config.sv
// Mode register bank for eight sockets, with decoded options per socket.
// Assumes a host-port front end that presents byte reads and writes
// already synchronous to i_core_clk.
// Option outputs are plain decodes of the stored bytes.
//
// Summary of operation
// RL1 - Eight 8-bit RW mode registers, reset zero
// RL2 - Bit 7 enables multicast, UDP only
// RL3 - Host loads group address before open
// RL4 - Bit 6 filters frames in raw Ethernet
// RL5 - Host should set filter in hybrid stack
// RL6 - Bit 5 gives immediate ack in TCP
// RL7 - Bit 5 selects IGMP version in multicast
// RL8 - Bits 3:0 encode socket protocol
// RL9 - Raw Ethernet and PPPoE only on socket 0
// RL10 - PPPoE on socket 0 may be reprogrammed
// RL11 - Open maps protocol to status code
// RL12 - Reserved bit 4 reads zero
`timescale 1ns/1ps
`include "socket_mode_defines.svh"

module socket_mode_config #(
   parameter int NUM_SOCK = 8
) (
   // Clock, reset, enable
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rstn,
   input  wire logic                        i_ce,
   // Host register port
   input  wire logic                        i_wr_en,
   input  wire logic                        i_rd_en,
   input  wire logic [15:0]                 i_addr,
   input  wire logic [7:0]                  i_wdata,
   output logic      [7:0]                  o_rdata,
   output logic                             o_hit,
   // Open command per socket
   input  wire logic [NUM_SOCK-1:0]         i_open,
   // Decoded options per socket
   output socket_mode_pkg::proto_t          o_proto [NUM_SOCK],
   output logic      [NUM_SOCK-1:0]         o_multicast_en,
   output logic      [NUM_SOCK-1:0]         o_mac_filter_enable,
   output logic      [NUM_SOCK-1:0]         o_immediate_ack_enable,
   output logic      [NUM_SOCK-1:0]         o_igmp_v1,
   output logic      [7:0]                  o_socket_state [NUM_SOCK]
);
   import socket_mode_pkg::*;

   logic [7:0] socket_mode_reg_r [NUM_SOCK];
   logic [7:0] rdata_nxt;
   logic       hit_nxt;
   logic [2:0] sel;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // The base plus one of eight socket strides with low byte zero hits a register
   function automatic logic addr_hit(input logic [15:0] a);
      addr_hit = (a & `SM_SOCK_MASK) == `SM_BASE_ADDR;
   endfunction

   // Protocol honoured only if legal on this socket
   function automatic proto_t legal_proto(input logic [7:0] m, input int s);
      logic [3:0] p;
      p = m[`SM_PROTO_HI:`SM_PROTO_LO];
      // RL9 socket zero only
      if ((p == 4'(PROTO_RAWETH) || p == 4'(PROTO_PPPOE)) && s == 0) begin
         legal_proto = proto_t'(p);
      end else if (p <= 4'(PROTO_RAW_IP_MODE)) begin
         legal_proto = proto_t'(p);
      end else begin
         legal_proto = PROTO_CLOSED;
      end
   endfunction

   assign sel = i_addr[10:8];

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   // RL1 writable registers, RL12 reserved bit masked, RL10 rewrite allowed
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int s = 0; s < NUM_SOCK; s++) begin
            socket_mode_reg_r[s] <= `SM_RESET_VAL;
         end
      end else if (i_ce && i_wr_en && addr_hit(i_addr) && int'(sel) < NUM_SOCK) begin
         socket_mode_reg_r[sel] <= i_wdata & `SM_WRITE_MASK;
      end
   end

   // Read mux; unmapped reads answer zero
   always_comb begin
      hit_nxt   = addr_hit(i_addr) && int'(sel) < NUM_SOCK;
      rdata_nxt = hit_nxt ? socket_mode_reg_r[sel] : `SM_UNMAPPED_RD;
   end

   // Read data registered for a clean answer one cycle later
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= `SM_RESET_VAL;
      end else if (i_ce && i_rd_en) begin
         o_rdata <= rdata_nxt;
      end
   end

   assign o_hit = hit_nxt;

   // ---------------------------------------------------------------
   // Option decode
   // ---------------------------------------------------------------
   // Each option is gated by the protocol it belongs to
   // Kept combinational off the flip-flops so a new mode reaches
   // the engines one edge after the write, at no extra latency
   always_comb begin
      for (int s = 0; s < NUM_SOCK; s++) begin
         o_proto[s] = legal_proto(socket_mode_reg_r[s], s);
         // RL2 multicast UDP only
         o_multicast_en[s] = socket_mode_reg_r[s][`SM_MULTI_BIT] && o_proto[s] == PROTO_UDP;
         // RL4 filter in raw Ethernet
         o_mac_filter_enable[s] = socket_mode_reg_r[s][`SM_MACF_BIT]
                                  && o_proto[s] == PROTO_RAWETH;
         // RL6 immediate ack TCP
         o_immediate_ack_enable[s] = socket_mode_reg_r[s][`SM_ACKV_BIT]
                                     && o_proto[s] == PROTO_TCP;
         // RL7 IGMP version select
         o_igmp_v1[s] = socket_mode_reg_r[s][`SM_ACKV_BIT] && o_multicast_en[s];
      end
   end

   // ---------------------------------------------------------------
   // Status after open
   // ---------------------------------------------------------------
   // RL11 open sets status; RL8 encoding drives it
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int s = 0; s < NUM_SOCK; s++) begin
            o_socket_state[s] <= `SM_ST_CLOSED;
         end
      end else if (i_ce) begin
         for (int s = 0; s < NUM_SOCK; s++) begin
            if (i_open[s]) begin
               case (o_proto[s])
                  PROTO_TCP:    o_socket_state[s] <= `SM_ST_TCP;
                  PROTO_UDP:    o_socket_state[s] <= `SM_ST_UDP;
                  PROTO_RAW_IP_MODE:  o_socket_state[s] <= `SM_ST_RAW_IP_MODE;
                  PROTO_RAWETH: o_socket_state[s] <= `SM_ST_RAWETH;
                  PROTO_PPPOE:  o_socket_state[s] <= `SM_ST_PPPOE;
                  default:      o_socket_state[s] <= o_socket_state[s];
               endcase
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL12
      socket_mode_reg_r[sel][`SM_RSVD_BIT] == 1'b0)
      else $error("reserved bit set");
   a_write_stores: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
      i_ce && i_wr_en && hit_nxt |=> socket_mode_reg_r[$past(sel)] ==
      ($past(i_wdata) & `SM_WRITE_MASK))
      else $error("write not stored");
   a_multi_udp: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL2
      o_multicast_en[1] |-> o_proto[1] == PROTO_UDP)
      else $error("multicast outside udp");
   a_filter_raw: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL4
      o_mac_filter_enable[0]
      |-> socket_mode_reg_r[0][`SM_PROTO_HI:`SM_PROTO_LO] == 4'(PROTO_RAWETH))
      else $error("filter outside raw mode");
   a_ack_tcp: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL6
      o_immediate_ack_enable[2] |-> o_proto[2] == PROTO_TCP && !o_igmp_v1[2])
      else $error("ack option outside tcp");
   a_igmp_sel: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL7
      o_igmp_v1[3] |-> o_multicast_en[3] && socket_mode_reg_r[3][`SM_ACKV_BIT])
      else $error("igmp version without multicast");
   a_sock1_noraw: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL9
      o_proto[1] != PROTO_RAWETH && o_proto[1] != PROTO_PPPOE)
      else $error("raw mode on socket 1");
   a_open_tcp: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL11
      i_ce && i_open[0] && o_proto[0] == PROTO_TCP |=> o_socket_state[0] == `SM_ST_TCP)
      else $error("tcp open status wrong");
   a_open_pppoe: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL8
      i_ce && i_open[0] && o_proto[0] == PROTO_PPPOE |=> o_socket_state[0] == `SM_ST_PPPOE)
      else $error("pppoe open status wrong");
   a_open_udp: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL11
      i_ce && i_open[3] && o_proto[3] == PROTO_UDP |=> o_socket_state[3] == `SM_ST_UDP)
      else $error("udp open status wrong");

   // ---------------------------------------------------------------
   // Enable, hold and decode checks
   // ---------------------------------------------------------------
   // A frozen enable must keep the socket 1 stored byte and the read data
   a_ce_freeze_reg: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
      !i_ce |=> socket_mode_reg_r[1] == $past(socket_mode_reg_r[1])
      && o_rdata == $past(o_rdata))
      else $error("register changed while frozen");
   a_ce_freeze_state: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL11
      !i_ce |=> o_socket_state[1] == $past(o_socket_state[1]))
      else $error("status changed while frozen");
   // Writes that miss the bank leave socket 0 alone
   a_miss_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
      i_wr_en && !hit_nxt |=> socket_mode_reg_r[0] == $past(socket_mode_reg_r[0]))
      else $error("unmapped write stored");
   // Read data stands until the next read
   a_rdata_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
      !i_rd_en |=> o_rdata == $past(o_rdata))
      else $error("read data moved without a read");
   // Opening a closed socket leaves its status where it was
   a_closed_keeps: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL11
      i_ce && i_open[2] && o_proto[2] == PROTO_CLOSED
      |=> o_socket_state[2] == $past(o_socket_state[2]))
      else $error("closed open changed status");
   // Raw Ethernet is honoured on socket 0
   a_raw_sock0: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL9
      socket_mode_reg_r[0][`SM_PROTO_HI:`SM_PROTO_LO] == 4'(PROTO_RAWETH)
      |-> o_proto[0] == PROTO_RAWETH)
      else $error("raw mode lost on socket 0");

   // Main scenarios
   c_udp_multi: cover property (@(posedge i_core_clk) o_multicast_en[0] && o_igmp_v1[0]);
   c_raw_filter: cover property (@(posedge i_core_clk) o_mac_filter_enable[0]);
   c_tcp_open: cover property (@(posedge i_core_clk) o_socket_state[4] == `SM_ST_TCP);
   c_frozen_write: cover property (@(posedge i_core_clk) !i_ce && i_wr_en && hit_nxt);
   c_pppoe_open: cover property (@(posedge i_core_clk) o_socket_state[0] == `SM_ST_PPPOE);
endmodule

// >>> hw/socket_mode_defines.svh
// Constants for the per-socket mode register bank.
// Assumes inclusion by the design module only.
`ifndef SOCKET_MODE_DEFINES_SVH
`define SOCKET_MODE_DEFINES_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SM_BASE_ADDR     16'h4000
`define SM_SOCK_STRIDE   16'h0100
`define SM_SOCK_MASK     16'hf8ff
`define SM_RESET_VAL     8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SM_MULTI_BIT     7
`define SM_MACF_BIT      6
`define SM_ACKV_BIT      5
`define SM_RSVD_BIT      4
`define SM_WRITE_MASK    8'hef
`define SM_PROTO_HI      3
`define SM_PROTO_LO      0
`define SM_UNMAPPED_RD   8'h00

// ---------------------------------------------------------------
// Status codes after open
// ---------------------------------------------------------------
`define SM_ST_CLOSED     8'h00
`define SM_ST_TCP        8'h13
`define SM_ST_UDP        8'h22
`define SM_ST_RAW_IP_MODE      8'h32
`define SM_ST_RAWETH     8'h42
`define SM_ST_PPPOE      8'h5f

`endif

// >>> hw/socket_mode_pkg.sv
// Types for the per-socket mode register bank.
// Assumes the defines header sits beside it.
package socket_mode_pkg;
   // Protocol field encodings
   typedef enum logic [3:0] {
      PROTO_CLOSED = 4'h0,
      PROTO_TCP    = 4'h1,
      PROTO_UDP    = 4'h2,
      PROTO_RAW_IP_MODE  = 4'h3,
      PROTO_RAWETH = 4'h4,
      PROTO_PPPOE  = 4'h5
   } proto_t;
endpackage
